// File: bench/tcb_pins.sv
// far side model: bursts of pulses on the channel pins
`timescale 1ns/1ps
`default_nettype none
module tcb_pins (
  input wire logic ref_clk,
  input wire logic start,
  output logic pin0,
  output logic pin1,
  output logic pinm
);
  // eight 6-cycle pulses, moved off the edge like a real pin
  initial
  begin
    {pin0, pin1, pinm} = 3'h0;
    forever
    begin
      @(posedge start);
      repeat (8)
      begin
        repeat (6) @(posedge ref_clk);
        #7 {pin0, pin1, pinm} = 3'h7;
        repeat (6) @(posedge ref_clk);
        #7 {pin0, pin1, pinm} = 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/tcb_timer_chk.sv
// port assertions for the capture and timebase block
`timescale 1ns/1ps
`default_nettype none
module tcb_timer_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire tcb_pkg::tcb_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic chan0_compare_ref,
  input wire logic chan0_output,
  input wire logic multi_chan0_output,
  input wire logic chan0_capture_pulse,
  input wire logic update_event_pulse,
  input wire logic [15:0] counter_value,
  input wire logic [19:0] chan0_compare_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // read strobe at one offset
  sequence s_rd(a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  property p_unmapped;
    s_rd(8'h40) |=> bus_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read gave data");
  property p_enpol;
    s_rd(8'h20) |=> bus_rdata[31:8] == 24'h0 && !bus_rdata[6];
  endproperty
  a_enpol: assert property (p_enpol)
    else $error("reserved enable bits set");
  property p_reload;
    s_rd(8'h2C) |=> bus_rdata[27:16] == 12'h0;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload reserved bits set");
  // counter read shows the integer count only
  property p_count;
    s_rd(8'h24) |=> bus_rdata == {16'h0, $past(counter_value)};
  endproperty
  a_count: assert property (p_count)
    else $error("counter read wrong");
  property p_freeze;
    !clk_en |=> $stable(counter_value) && $stable(chan0_compare_active);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");
  // outputs move only after a reference edge or a write
  property p_out0;
    $changed(chan0_output) |-> $past(bus_req.wr) || $past(bus_req.wr, 2)
      || $past(chan0_compare_ref) != $past(chan0_compare_ref, 2);
  endproperty
  a_out0: assert property (p_out0)
    else $error("channel output moved alone");
  property p_outm;
    $changed(multi_chan0_output) |-> $past(bus_req.wr)
      || $past(bus_req.wr, 2)
      || $past(chan0_compare_ref) != $past(chan0_compare_ref, 2);
  endproperty
  a_outm: assert property (p_outm)
    else $error("multi output moved alone");
  property p_active;
    $changed(chan0_compare_active) |-> update_event_pulse
      || $past(update_event_pulse) || $past(bus_req.wr, 2)
      || $past(chan0_capture_pulse);
  endproperty
  a_active: assert property (p_active)
    else $error("active compare moved alone");
endmodule
bind tcb_timer tcb_timer_chk i_tcb_timer_chk (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .chan0_compare_ref(chan0_compare_ref),
  .chan0_output(chan0_output), .multi_chan0_output(multi_chan0_output),
  .chan0_capture_pulse(chan0_capture_pulse),
  .update_event_pulse(update_event_pulse),
  .counter_value(counter_value),
  .chan0_compare_active(chan0_compare_active)
);
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the capture and timebase block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic cref = 1'b0;
  logic start = 1'b0;
  logic rd_d = 1'b0;
  logic p0, p1, pm, o0, om, cp0, cp1, up;
  logic [31:0] d, rdata, got_e;
  logic [15:0] cnt;
  logic [19:0] act;
  tcb_pkg::tcb_bus_req_t req = '0;
  logic [31:0] exp_q [$];
  int num_errors = 0;
  int total_checks = 0;
  int n0 = 0;
  int n1 = 0;
  int seed = 92100;
  logic [7:0] ra [8] = '{8'h18, 8'h20, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C,
    8'h40};
  // capture table: control, enables, ch0 and ch1 capture counts
  logic [31:0] tc [13] = '{32'h1, 32'h5, 32'h9, 32'hD, 32'h1, 32'h1,
    32'h21, 32'h31, 32'h501, 32'h40000000, 32'h40000000, 32'h2, 32'h3};
  logic [7:0] te [13] = '{8'h1, 8'h1, 8'h1, 8'h1, 8'h3, 8'hB, 8'h1, 8'h1,
    8'h11, 8'h5, 8'h1, 8'h1, 8'h1};
  int t0 [13] = '{8, 4, 2, 1, 8, 16, 8, 0, 8, 8, 0, 8, 8};
  int t1 [13] = '{0, 0, 0, 0, 0, 0, 0, 0, 4, 0, 0, 0, 0};
  always #12.5 ref_clk = ~ref_clk;
  tcb_pins i_tcb_pins (.ref_clk(ref_clk), .start(start), .pin0(p0),
    .pin1(p1), .pinm(pm));
  // trigger source shares the neighbour pin to keep inputs live
  tcb_timer i_tcb_timer (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .bus_req(req), .bus_rdata(rdata), .chan0_raw_input(p0),
    .chan1_raw_input(p1), .multi_chan0_raw_input(pm),
    .internal_trigger(p1), .chan0_compare_ref(cref), .chan0_output(o0),
    .multi_chan0_output(om), .chan0_capture_pulse(cp0),
    .chan1_capture_pulse(cp1), .update_event_pulse(up),
    .counter_value(cnt), .chan0_compare_active(act));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // expectation queued here, compared by the read monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // spacing of update pulses in cycles
  task automatic gap(input int e);
    int c;
    c = 0;
    @(negedge ref_clk iff up === 1'b1);
    do
    begin
      @(negedge ref_clk);
      c++;
    end
    while (up !== 1'b1);
    `CHK("update gap", e, c)
    @(posedge ref_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    rd_d <= req.rd;
    n0 += (cp0 === 1'b1);
    n1 += (cp1 === 1'b1);
  end
  always @(negedge ref_clk)
  begin
    if (rd_d)
    begin
      got_e = exp_q.pop_front();
      if (^got_e !== 1'bx) `CHK("read data", got_e, rdata)
    end
  end
  initial
  begin
    #500000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (ra[i]) rd(ra[i], ra[i] == 8'h2C ? 32'hFFFF : 32'h0);
    d = $random(seed);
    wr(8'h20, d);
    rd(8'h20, d & 32'hBF);
    wr(8'h20, 32'h0);
    wr(8'h28, d);
    rd(8'h28, d & 32'hFFFF);
    wr(8'h2C, d);
    rd(8'h2C, d & 32'h0000FFFF);
    wr(8'h30, d);
    rd(8'h30, d & 32'hFF);
    $display("test registers done");
    // clearing the enables first also resets the edge dividers
    for (int i = 0; i < 13; i++)
    begin
      wr(8'h20, 32'h0);
      wr(8'h18, tc[i]);
      wr(8'h20, te[i]);
      n0 = 0;
      n1 = 0;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (110) @(posedge ref_clk);
      `CHK("ch0 captures", t0[i], n0)
      `CHK("ch1 captures", t1[i], n1)
    end
    $display("test capture done");
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h3C, 32'hC0);
    cref <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h20, {28'h0, p[1], 1'b1, p[0], 1'b1});
      @(negedge ref_clk);
      `CHK("ch0 out", ~p[0], o0)
      `CHK("multi out", ~p[1], om)
      @(posedge ref_clk);
    end
    $display("test outputs done");
    wr(8'h30, 32'h0);
    wr(8'h2C, 32'h9);
    wr(8'h28, 32'h3);
    wr(8'h3C, 32'h20);
    gap(40);
    wr(8'h30, 32'h2);
    gap(120);
    wr(8'h3C, 32'h22);
    gap(40);
    rd(8'h24, 'x);
    clk_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
    clk_en <= 1'b1;
    $display("test timebase done");
    wr(8'h3C, 32'h33);
    wr(8'h34, 32'h50001234);
    @(negedge ref_clk iff up === 1'b1);
    `CHK("active compare", 20'h51234, act)
    @(posedge ref_clk);
    rd(8'h34, 32'h50001234);
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h34, 32'hABCD);
    rd(8'h34, 32'h1234);
    wr(8'h18, 32'h0);
    wr(8'h20, 32'hF);
    wr(8'h3C, 32'hCC);
    wr(8'h20, 32'h5);
    rd(8'h20, 32'hF);
    $display("test values done");
    end_of_test();
  end
endmodule
`default_nettype wire

// File: hw/tcb_cap_filter.sv
// digital input filter with sampling divider and agreement counter
`timescale 1ns/1ps
`default_nettype none
module tcb_cap_filter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] flt_code,
  input wire logic sample_in,
  output logic filt_out
);

  logic [4:0] div_cnt_reg; // free running sample divider
  logic [3:0] agree_cnt_reg; // samples seen at the new level
  logic filt_reg; // filtered level
  logic [4:0] div_mask;
  logic [3:0] need_len;
  logic sample_tick;
  logic [3:0] agree_next;

  assign div_mask = tcb_pkg::filt_div_mask(flt_code);
  assign need_len = tcb_pkg::filt_len(flt_code);
  assign sample_tick = (div_cnt_reg & div_mask) == 5'h00;
  assign agree_next = agree_cnt_reg + 4'h1;
  assign filt_out = filt_reg;

  // divider; sample tick every 1, 2, 4, 8, 16 or 32 kernel clocks per the code
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      div_cnt_reg <= 5'h00;
    else if (clk_en)
      div_cnt_reg <= div_cnt_reg + 5'h01;
  end

  // any disagreeing sample restarts the run, so glitches shorter than N samples never pass
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      agree_cnt_reg <= 4'h0;
      filt_reg <= 1'b0;
    end
    else if (clk_en && sample_tick)
    begin
      if (sample_in == filt_reg)
        agree_cnt_reg <= 4'h0;
      else if (agree_next >= need_len)
      begin
        // level held for N samples
        filt_reg <= sample_in;
        agree_cnt_reg <= 4'h0;
      end
      else
        agree_cnt_reg <= agree_next;
    end
  end

endmodule
`default_nettype wire

// File: hw/tcb_pkg.sv
// shared constants, types and helpers for the capture and timebase block
package tcb_pkg;

  // register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [7:0] OFF_CAP_CTL = 8'h18;
  localparam logic [7:0] OFF_EN_POL = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_DIVIDER = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2C;
  localparam logic [7:0] OFF_REPEAT = 8'h30;
  localparam logic [7:0] OFF_CH0_VAL = 8'h34;
  localparam logic [7:0] OFF_CONFIG = 8'h3C;

  // values after reset
  localparam logic [31:0] RST_CAP_CTL = 32'h0000_0000;
  localparam logic [7:0] RST_EN_POL = 8'h00;
  localparam logic [15:0] RST_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'hFFFF;
  localparam logic [7:0] RST_REPEAT = 8'h00;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [3:0] RST_FRAC = 4'h0;

  // writable bit masks, everything else is reserved
  localparam logic [31:0] CAP_CTL_MASK = 32'h4000_FFFF;
  localparam logic [31:0] ROLE0_MASK = 32'h4000_0003;
  localparam logic [31:0] ROLE1_MASK = 32'h0000_0300;
  localparam logic [7:0] EN_POL_MASK = 8'hBF;

  // capture control field positions
  localparam int ROLE0_LSB = 0;
  localparam int ROLE0_TOP = 30;
  localparam int DIV0_LSB = 2;
  localparam int FLT0_LSB = 4;
  localparam int ROLE1_LSB = 8;
  localparam int DIV1_LSB = 10;
  localparam int FLT1_LSB = 12;

  // enable and polarity bit positions
  localparam int CH0_EN_BIT = 0;
  localparam int CH0_POL_BIT = 1;
  localparam int MC0_EN_BIT = 2;
  localparam int MC0_POL_BIT = 3;
  localparam int CH1_EN_BIT = 4;
  localparam int CH1_POL_BIT = 5;
  localparam int MC1_POL_BIT = 7;

  // fraction nibble position in value words
  localparam int FRAC_LSB = 28;

  // channel role codes
  typedef enum logic [2:0] {
    ROLE_OUTPUT = 3'b000,
    ROLE_OWN_IN = 3'b001,
    ROLE_NEIGH_IN = 3'b010,
    ROLE_TRIG_IN = 3'b011,
    ROLE_MULTI_IN = 3'b100
  } tcb_role_t;

  localparam logic [1:0] MSEL_COMPLEMENT = 2'b11;
  localparam logic [1:0] PROTECTION_LEVEL_LEVEL_1 = 2'b10;
  localparam logic [1:0] PROTECTION_LEVEL_LEVEL_2 = 2'b11;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tcb_bus_req_t;

  // configuration word, bit 7 downward
  typedef struct packed {
    logic [1:0] mode_sel;
    logic cnt_enable;
    logic shadow0;
    logic [1:0] protection_level;
    logic repeat_select;
    logic frac_enable;
  } tcb_cfg_t;

  localparam logic [7:0] RST_CONFIG = 8'h00;

  // filter length N for a filter code
  function automatic logic [3:0] filt_len(input logic [3:0] code);
    case (code)
      4'h0: filt_len = 4'h1;
      4'h1: filt_len = 4'h2;
      4'h2: filt_len = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filt_len = 4'h6;
      4'hA, 4'hD: filt_len = 4'h5;
      default: filt_len = 4'h8;
    endcase
  endfunction

  // sample period mask, as divider minus one, for a filter code
  function automatic logic [4:0] filt_div_mask(input logic [3:0] code);
    case (code)
      4'h4, 4'h5: filt_div_mask = 5'h01;
      4'h6, 4'h7: filt_div_mask = 5'h03;
      4'h8, 4'h9: filt_div_mask = 5'h07;
      4'hA, 4'hB, 4'hC: filt_div_mask = 5'h0F;
      4'hD, 4'hE, 4'hF: filt_div_mask = 5'h1F;
      default: filt_div_mask = 5'h00;
    endcase
  endfunction

  // edge divider terminal count mask
  function automatic logic [2:0] edge_div_mask(input logic [1:0] code);
    case (code)
      2'b01: edge_div_mask = 3'h1;
      2'b10: edge_div_mask = 3'h3;
      2'b11: edge_div_mask = 3'h7;
      default: edge_div_mask = 3'h0;
    endcase
  endfunction

  // edge qualify from polarity pair {multi, channel}
  function automatic logic edge_match(input logic [1:0] pol,
                                      input logic rise,
                                      input logic fall);
    case (pol)
      2'b01: edge_match = fall;
      2'b11: edge_match = rise | fall;
      default: edge_match = rise;
    endcase
  endfunction

endpackage

// File: hw/tcb_timer.sv
// two channel capture, channel 0 compare, with prescaled, repeated timebase
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tcb_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire tcb_pkg::tcb_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic chan0_raw_input,
  input wire logic chan1_raw_input,
  input wire logic multi_chan0_raw_input,
  input wire logic internal_trigger,
  input wire logic chan0_compare_ref,
  output logic chan0_output,
  output logic multi_chan0_output,
  output logic chan0_capture_pulse,
  output logic chan1_capture_pulse,
  output logic update_event_pulse,
  output logic [15:0] counter_value,
  output logic [19:0] chan0_compare_active
);

  // pin synchronisers, {multi0, ch1, ch0}
  logic [2:0] sync_a_reg;
  logic [2:0] sync_b_reg;

  // software visible storage
  logic [31:0] cap_ctl_reg; // capture control
  logic [7:0] en_pol_reg; // enables and polarities
  tcb_pkg::tcb_cfg_t cfg_reg; // block configuration
  logic [15:0] divider_reg; // counter clock divider preload
  logic [15:0] reload_reg; // reload integer part
  logic [3:0] reload_frac_reg; // reload fraction
  logic [7:0] repeat_reg; // repeat value 0
  logic [15:0] value_reg; // ch0 compare or capture value
  logic [3:0] value_frac_reg; // ch0 compare fraction

  // timebase state
  logic [15:0] divider_shadow_reg;
  logic [15:0] div_cnt_reg;
  logic [15:0] count_reg;
  logic [7:0] rep_cnt_reg;
  logic [19:0] cmp_active_reg;
  logic update_reg;

  // capture state
  logic src0_prev_reg;
  logic src1_prev_reg;
  logic [2:0] edge0_cnt_reg;
  logic [2:0] edge1_cnt_reg;
  logic cap0_reg;
  logic cap1_reg;
  logic out0_reg;
  logic mout0_reg;
  logic [31:0] rdata_reg;

  // field views
  tcb_pkg::tcb_role_t role0;
  logic [1:0] role1;
  logic ch0_en;
  logic ch0_pol;
  logic mc0_en;
  logic mc0_pol;
  logic ch1_en;
  logic ch1_pol;
  logic mc1_pol;
  logic ch0_is_out;
  logic ch1_is_out;

  assign role0 = tcb_pkg::tcb_role_t'({cap_ctl_reg[tcb_pkg::ROLE0_TOP],
    cap_ctl_reg[tcb_pkg::ROLE0_LSB +: 2]});
  assign role1 = cap_ctl_reg[tcb_pkg::ROLE1_LSB +: 2];
  assign ch0_en = en_pol_reg[tcb_pkg::CH0_EN_BIT];
  assign ch0_pol = en_pol_reg[tcb_pkg::CH0_POL_BIT];
  assign mc0_en = en_pol_reg[tcb_pkg::MC0_EN_BIT];
  assign mc0_pol = en_pol_reg[tcb_pkg::MC0_POL_BIT];
  assign ch1_en = en_pol_reg[tcb_pkg::CH1_EN_BIT];
  assign ch1_pol = en_pol_reg[tcb_pkg::CH1_POL_BIT];
  assign mc1_pol = en_pol_reg[tcb_pkg::MC1_POL_BIT];
  assign ch0_is_out = role0 == tcb_pkg::ROLE_OUTPUT;
  assign ch1_is_out = role1 == 2'b00;

  // write decode
  logic wr_cap;
  logic wr_enp;
  logic wr_div;
  logic wr_rel;
  logic wr_rep;
  logic wr_val;
  logic wr_cfg;
  assign wr_cap = bus_req.wr && bus_req.addr == tcb_pkg::OFF_CAP_CTL;
  assign wr_enp = bus_req.wr && bus_req.addr == tcb_pkg::OFF_EN_POL;
  assign wr_div = bus_req.wr && bus_req.addr == tcb_pkg::OFF_DIVIDER;
  assign wr_rel = bus_req.wr && bus_req.addr == tcb_pkg::OFF_RELOAD;
  assign wr_rep = bus_req.wr && bus_req.addr == tcb_pkg::OFF_REPEAT;
  assign wr_cfg = bus_req.wr && bus_req.addr == tcb_pkg::OFF_CONFIG;
  // capture owns the value in input mode, so software cannot write it
  assign wr_val = bus_req.wr && bus_req.addr == tcb_pkg::OFF_CH0_VAL
    && ch0_is_out;

  // role select only changes while its channel is idle
  logic [31:0] cap_wmask;
  logic [31:0] cap_ctl_next;
  assign cap_wmask = tcb_pkg::CAP_CTL_MASK
    & ~((ch0_en || mc0_en) ? tcb_pkg::ROLE0_MASK : 32'h0000_0000)
    & ~(ch1_en ? tcb_pkg::ROLE1_MASK : 32'h0000_0000);
  assign cap_ctl_next = (cap_ctl_reg & ~cap_wmask)
    | (bus_req.wdata & cap_wmask);

  // polarity bits locked at higher protection levels: multi 0 always, the rest only for output channels
  logic protection_level_high;
  logic [7:0] enp_lock;
  logic [7:0] enp_wmask;
  logic [7:0] en_pol_next;
  assign protection_level_high = cfg_reg.protection_level == tcb_pkg::PROTECTION_LEVEL_LEVEL_1
    || cfg_reg.protection_level == tcb_pkg::PROTECTION_LEVEL_LEVEL_2;
  assign enp_lock = (8'h01 << tcb_pkg::MC0_POL_BIT)
    | (ch0_is_out ? (8'h01 << tcb_pkg::CH0_POL_BIT) : 8'h00)
    | (ch1_is_out ? ((8'h01 << tcb_pkg::CH1_POL_BIT)
      | (8'h01 << tcb_pkg::MC1_POL_BIT)) : 8'h00);
  assign enp_wmask = tcb_pkg::EN_POL_MASK
    & ~(protection_level_high ? enp_lock : 8'h00);
  assign en_pol_next = (en_pol_reg & ~enp_wmask)
    | (bus_req.wdata[7:0] & enp_wmask);

  // timebase decode
  logic div_tick;
  logic overflow;
  logic rep_zero;
  logic update_evt;
  logic [7:0] rep_load;
  assign div_tick = cfg_reg.cnt_enable
    && div_cnt_reg == divider_shadow_reg;
  assign overflow = div_tick && count_reg == reload_reg;
  // with repeat select set the repeat value is bypassed
  assign rep_load = cfg_reg.repeat_select ? 8'h00 : repeat_reg;
  assign rep_zero = rep_cnt_reg == 8'h00;
  assign update_evt = overflow && rep_zero;

  // synchronise the pins before any logic looks at them
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a_reg <= 3'b000;
      sync_b_reg <= 3'b000;
    end
    else if (clk_en)
    begin
      sync_a_reg <= {multi_chan0_raw_input, chan1_raw_input,
        chan0_raw_input};
      sync_b_reg <= sync_a_reg;
    end
  end

  // input filters; the multi input shares the channel 0 code
  logic [2:0] filt;
  logic [3:0] flt_code0;
  logic [3:0] flt_code1;
  assign flt_code0 = cap_ctl_reg[tcb_pkg::FLT0_LSB +: 4];
  assign flt_code1 = cap_ctl_reg[tcb_pkg::FLT1_LSB +: 4];

  tcb_cap_filter u_filt_ch0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .flt_code(flt_code0),
    .sample_in(sync_b_reg[0]),
    .filt_out(filt[0])
  );

  tcb_cap_filter u_filt_ch1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .flt_code(flt_code1),
    .sample_in(sync_b_reg[1]),
    .filt_out(filt[1])
  );

  tcb_cap_filter u_filt_mc0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .flt_code(flt_code0),
    .sample_in(sync_b_reg[2]),
    .filt_out(filt[2])
  );

  // channel 0 source by role
  logic src0;
  assign src0 = role0 == tcb_pkg::ROLE_OWN_IN ? filt[0] :
    role0 == tcb_pkg::ROLE_NEIGH_IN ? filt[1] :
    role0 == tcb_pkg::ROLE_TRIG_IN ? internal_trigger :
    role0 == tcb_pkg::ROLE_MULTI_IN ? filt[2] : 1'b0;

  // channel 1 source by role
  logic src1;
  assign src1 = role1 == 2'b01 ? filt[1] :
    role1 == 2'b10 ? filt[0] :
    role1 == 2'b11 ? internal_trigger : 1'b0;

  // edge qualify and divide
  logic edge0;
  logic edge1;
  logic cap0_en;
  logic [2:0] mask0;
  logic [2:0] mask1;
  logic cap0_hit;
  logic cap1_hit;
  assign edge0 = tcb_pkg::edge_match({mc0_pol, ch0_pol},
    src0 & ~src0_prev_reg, ~src0 & src0_prev_reg);
  assign edge1 = tcb_pkg::edge_match({mc1_pol, ch1_pol},
    src1 & ~src1_prev_reg, ~src1 & src1_prev_reg);
  // multi input source also needs its own enable
  assign cap0_en = !ch0_is_out && ch0_en
    && (role0 != tcb_pkg::ROLE_MULTI_IN || mc0_en);
  assign mask0 = tcb_pkg::edge_div_mask(
    cap_ctl_reg[tcb_pkg::DIV0_LSB +: 2]);
  assign mask1 = tcb_pkg::edge_div_mask(
    cap_ctl_reg[tcb_pkg::DIV1_LSB +: 2]);
  assign cap0_hit = cap0_en && edge0 && edge0_cnt_reg == mask0;
  assign cap1_hit = !ch1_is_out && ch1_en && edge1
    && edge1_cnt_reg == mask1;

  // edge dividers, cleared while their channel is disabled
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      src0_prev_reg <= 1'b0;
      src1_prev_reg <= 1'b0;
      edge0_cnt_reg <= 3'h0;
      edge1_cnt_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      src0_prev_reg <= src0;
      src1_prev_reg <= src1;
      if (!ch0_en)
        edge0_cnt_reg <= 3'h0;
      else if (cap0_en && edge0)
        edge0_cnt_reg <= cap0_hit ? 3'h0 : edge0_cnt_reg + 3'h1;
      if (!ch1_en)
        edge1_cnt_reg <= 3'h0;
      else if (!ch1_is_out && edge1)
        edge1_cnt_reg <= cap1_hit ? 3'h0 : edge1_cnt_reg + 3'h1;
    end
  end

  // control registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_ctl_reg <= tcb_pkg::RST_CAP_CTL;
      en_pol_reg <= tcb_pkg::RST_EN_POL;
      cfg_reg <= tcb_pkg::RST_CONFIG;
      divider_reg <= tcb_pkg::RST_DIVIDER;
      reload_reg <= tcb_pkg::RST_RELOAD;
      reload_frac_reg <= tcb_pkg::RST_FRAC;
      repeat_reg <= tcb_pkg::RST_REPEAT;
    end
    else if (clk_en)
    begin
      if (wr_cap)
        cap_ctl_reg <= cap_ctl_next;
      if (wr_enp)
        en_pol_reg <= en_pol_next;
      if (wr_cfg)
        cfg_reg <= tcb_pkg::tcb_cfg_t'(bus_req.wdata[7:0]);
      if (wr_div)
        divider_reg <= bus_req.wdata[15:0];
      if (wr_rel)
      begin
        reload_reg <= bus_req.wdata[15:0];
        reload_frac_reg <= bus_req.wdata[tcb_pkg::FRAC_LSB +: 4];
      end
      if (wr_rep)
        repeat_reg <= bus_req.wdata[7:0];
    end
  end

  // channel 0 value: software compare or captured count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      value_reg <= tcb_pkg::RST_VALUE;
      value_frac_reg <= tcb_pkg::RST_FRAC;
    end
    else if (clk_en)
    begin
      if (cap0_hit)
        value_reg <= count_reg;
      else if (wr_val)
      begin
        value_reg <= bus_req.wdata[15:0];
        value_frac_reg <= bus_req.wdata[tcb_pkg::FRAC_LSB +: 4];
      end
    end
  end

  // timebase: divider, counter, repetition and shadows
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      divider_shadow_reg <= tcb_pkg::RST_DIVIDER;
      div_cnt_reg <= 16'h0000;
      count_reg <= 16'h0000;
      rep_cnt_reg <= 8'h00;
      cmp_active_reg <= 20'h00000;
      update_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      update_reg <= update_evt;
      if (cfg_reg.cnt_enable)
        div_cnt_reg <= div_tick ? 16'h0000 : div_cnt_reg + 16'h0001;
      if (div_tick)
        count_reg <= overflow ? 16'h0000 : count_reg + 16'h0001;
      if (overflow)
        rep_cnt_reg <= rep_zero ? rep_load : rep_cnt_reg - 8'h01;
      if (update_evt)
        divider_shadow_reg <= divider_reg;
      // without shadow the compare copies the value register every cycle, one cycle after a write lands
      if (!cfg_reg.shadow0 || update_evt)
        cmp_active_reg <= {value_frac_reg, value_reg};
    end
  end

  // channel outputs; disabled means held low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      out0_reg <= 1'b0;
      mout0_reg <= 1'b0;
      cap0_reg <= 1'b0;
      cap1_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      out0_reg <= ch0_is_out && ch0_en
        && (chan0_compare_ref ^ ch0_pol);
      mout0_reg <= ch0_is_out && mc0_en
        && cfg_reg.mode_sel == tcb_pkg::MSEL_COMPLEMENT
        && (chan0_compare_ref ^ mc0_pol);
      cap0_reg <= cap0_hit;
      cap1_reg <= cap1_hit;
    end
  end

  // read view; fraction nibbles show only in fractional mode
  logic [3:0] rel_frac_rd;
  logic [3:0] val_frac_rd;
  logic [31:0] rd_mux;
  assign rel_frac_rd = cfg_reg.frac_enable ? reload_frac_reg : 4'h0;
  assign val_frac_rd = (cfg_reg.frac_enable && ch0_is_out)
    ? value_frac_reg : 4'h0;
  assign rd_mux =
    bus_req.addr == tcb_pkg::OFF_CAP_CTL ? cap_ctl_reg :
    bus_req.addr == tcb_pkg::OFF_EN_POL ? {24'h000000, en_pol_reg} :
    bus_req.addr == tcb_pkg::OFF_COUNT ? {16'h0000, count_reg} :
    bus_req.addr == tcb_pkg::OFF_DIVIDER ? {16'h0000, divider_reg} :
    bus_req.addr == tcb_pkg::OFF_RELOAD ?
      {rel_frac_rd, 12'h000, reload_reg} :
    bus_req.addr == tcb_pkg::OFF_REPEAT ? {24'h000000, repeat_reg} :
    bus_req.addr == tcb_pkg::OFF_CH0_VAL ?
      {val_frac_rd, 12'h000, value_reg} :
    bus_req.addr == tcb_pkg::OFF_CONFIG ? {24'h000000, cfg_reg} :
    32'h0000_0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= 32'h0000_0000;
    else if (clk_en)
      rdata_reg <= bus_req.rd ? rd_mux : 32'h0000_0000;
  end

  assign bus_rdata = rdata_reg;
  assign chan0_output = out0_reg;
  assign multi_chan0_output = mout0_reg;
  assign chan0_capture_pulse = cap0_reg;
  assign chan1_capture_pulse = cap1_reg;
  assign update_event_pulse = update_reg;
  assign counter_value = count_reg;
  assign chan0_compare_active = cmp_active_reg;

endmodule
`default_nettype wire
